// file: frt_core.sv
// Free-running 16-bit timer counter with prescaler, external clock and overflow flag.
// Assumes the CPU core strobes byte reads and writes on i_core_clk, one cycle each.
`timescale 1ns/100ps
`default_nettype none

module frt_core (
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_clk_en,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_ext_clock_pin,
    input  wire logic       i_ext_pin_bonded,
    input  wire logic       i_cpu_irq_mask,
    input  wire logic       i_halt_mode,
    output logic [7:0]      o_rdata,
    output logic            o_timer_irq
);
    import frt_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] count;
    logic [7:0]  timer_control_one;
    logic [7:0]  timer_control_two;
    logic        overflow_flag;
    logic        clear_armed;
    logic        seq_pending;
    logic [7:0]  low_buffer;
    logic [2:0]  prescale;
    logic        ext_sync_a;
    logic        ext_sync_b;
    logic        ext_prev;
    logic [7:0]  rdata;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire sel_ctrl_one = (i_addr == FRT_OFS_CTRL_ONE);
    wire sel_ctrl_two = (i_addr == FRT_OFS_CTRL_TWO);
    wire sel_status   = (i_addr == FRT_OFS_STATUS);
    wire sel_cnt_hi   = (i_addr == FRT_OFS_CNT_HI);
    wire sel_cnt_lo   = (i_addr == FRT_OFS_CNT_LO);
    wire sel_alt_hi   = (i_addr == FRT_OFS_ALT_HI);
    wire sel_alt_lo   = (i_addr == FRT_OFS_ALT_LO);

    wire run         = i_clk_en && !i_halt_mode;
    wire any_lo      = sel_cnt_lo || sel_alt_lo;
    wire rd_hi       = i_rd && (sel_cnt_hi || sel_alt_hi);
    wire rd_lo       = i_rd && any_lo;
    wire wr_lo       = i_wr && any_lo;
    wire prim_lo_acc = (i_rd || i_wr) && sel_cnt_lo;

    wire       overflow_irq_enable   = timer_control_one[FRT_BIT_OVF_IRQ_EN];
    wire [1:0] timer_clock_select    = timer_control_two[FRT_BIT_CLK_SEL_LO +: 2];
    wire       ext_clock_edge_select = timer_control_two[FRT_BIT_EXT_EDGE];

    // Unbonded pin floats high internally
    wire ext_pin_level = i_ext_pin_bonded ? i_ext_clock_pin : 1'b1;

    // ------------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------------
    // Rising edge when select bit is 1, falling otherwise
    wire ext_edge = ext_clock_edge_select ? (ext_sync_b && !ext_prev)
                                          : (!ext_sync_b && ext_prev);
    // Edges closer than two CPU clocks may merge; the source must keep that spacing
    wire [2:0] div_mask = (timer_clock_select == FRT_SEL_DIV4) ? FRT_DIV4_MASK :
                          (timer_clock_select == FRT_SEL_DIV8) ? FRT_DIV8_MASK :
                          FRT_DIV2_MASK;
    wire ext_mode = (timer_clock_select == FRT_SEL_EXT);
    wire int_tick = ((prescale & div_mask) == div_mask);
    wire tick     = ext_mode ? ext_edge : int_tick;

    wire wrap           = tick && (count == FRT_MAX_COUNT);
    wire [15:0] next_count = wr_lo ? FRT_RELOAD_COUNT :
                             tick  ? count + 16'h0001 : count;

    // ------------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------------
    wire clear_now = clear_armed && prim_lo_acc;
    // A wrap in the clearing cycle wins over the clear
    wire next_overflow_flag = wrap ? 1'b1 : (clear_now ? 1'b0 : overflow_flag);
    wire next_clear_armed   = (i_rd && sel_status && overflow_flag) ? 1'b1 :
                              (clear_now ? 1'b0 : clear_armed);

    // ------------------------------------------------------------------
    // Coherent read
    // ------------------------------------------------------------------
    wire [7:0] lo_value = seq_pending ? low_buffer : count[7:0];
    wire [7:0] status_value = {2'h0, overflow_flag, 5'h00};
    wire [7:0] next_rdata =
        sel_ctrl_one ? timer_control_one :
        sel_ctrl_two ? timer_control_two :
        sel_status   ? status_value :
        (sel_cnt_hi || sel_alt_hi) ? count[15:8] :
        any_lo       ? lo_value : 8'h00;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= FRT_RELOAD_COUNT;
            prescale <= 3'h0;
        end else if (run) begin
            count <= next_count;
            prescale <= wr_lo ? 3'h0 : prescale + 3'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ext_sync_a <= 1'b1;
            ext_sync_b <= 1'b1;
            ext_prev   <= 1'b1;
        end else if (run) begin
            ext_sync_a <= ext_pin_level;
            ext_sync_b <= ext_sync_a;
            ext_prev   <= ext_sync_b;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            overflow_flag <= 1'b0;
            clear_armed   <= 1'b0;
        end else if (run) begin
            overflow_flag <= next_overflow_flag;
            clear_armed   <= next_clear_armed;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seq_pending <= 1'b0;
            low_buffer  <= 8'h00;
        end else if (i_clk_en) begin
            if (rd_hi && !seq_pending) begin
                low_buffer  <= count[7:0];
                seq_pending <= 1'b1;
            end else if (rd_lo) begin
                seq_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timer_control_one <= FRT_CTRL_RESET;
            timer_control_two <= FRT_CTRL_RESET;
        end else if (i_clk_en && i_wr) begin
            if (sel_ctrl_one)
                timer_control_one <= i_wdata;
            if (sel_ctrl_two)
                timer_control_two <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata <= 8'h00;
        end else if (i_clk_en) begin
            rdata <= i_rd ? next_rdata : 8'h00;
        end
    end

    assign o_rdata     = rdata;
    assign o_timer_irq = overflow_flag && overflow_irq_enable && !i_cpu_irq_mask;

endmodule : frt_core

`default_nettype wire

// file: frt_pkg.sv
// Package for the free-running timer counter core: register map, fields, reset values.
// Assumes a byte-wide register port from the CPU core on the same clock.
package frt_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] FRT_OFS_CTRL_ONE  = 4'h0;
    localparam logic [3:0] FRT_OFS_CTRL_TWO  = 4'h1;
    localparam logic [3:0] FRT_OFS_STATUS    = 4'h2;
    localparam logic [3:0] FRT_OFS_CNT_HI    = 4'h3;
    localparam logic [3:0] FRT_OFS_CNT_LO    = 4'h4;
    localparam logic [3:0] FRT_OFS_ALT_HI    = 4'h5;
    localparam logic [3:0] FRT_OFS_ALT_LO    = 4'h6;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FRT_BIT_OVF_IRQ_EN  = 5;
    localparam int FRT_BIT_CLK_SEL_LO  = 2;
    localparam int FRT_BIT_EXT_EDGE    = 0;
    localparam int FRT_BIT_OVF_FLAG    = 5;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [15:0] FRT_RELOAD_COUNT = 16'hFFFC;
    localparam logic [15:0] FRT_MAX_COUNT    = 16'hFFFF;
    localparam logic [7:0]  FRT_CTRL_RESET   = 8'h00;
    localparam logic [1:0]  FRT_SEL_DIV4     = 2'h0;
    localparam logic [1:0]  FRT_SEL_DIV8     = 2'h1;
    localparam logic [1:0]  FRT_SEL_DIV2     = 2'h2;
    localparam logic [1:0]  FRT_SEL_EXT      = 2'h3;
    localparam logic [2:0]  FRT_DIV2_MASK    = 3'h1;
    localparam logic [2:0]  FRT_DIV4_MASK    = 3'h3;
    localparam logic [2:0]  FRT_DIV8_MASK    = 3'h7;

endpackage : frt_pkg

// file: frt_ext_src.sv
// External clock source standing at the timer's clock pin.
// Assumes the bench starts and stops it between measurements.
`timescale 1ns/100ps
`default_nettype none
module frt_ext_src (
    input  wire logic i_core_clk,
    input  wire logic i_run,
    output logic      o_pin
);
    logic [2:0] gap;
    initial o_pin = 1'b0;
    // Toggle every fifth cycle: active edges stay ten cycles apart
    always @(posedge i_core_clk) begin
        gap <= (gap == 3'h4 || !i_run) ? 3'h0 : gap + 3'h1;
        if (i_run && gap == 3'h4) o_pin <= ~o_pin;
    end
endmodule : frt_ext_src
`default_nettype wire

// file: frt_core_chk.sv
// Port checks for the free-running timer counter core.
// Assumes it is bound to frt_core and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module frt_core_chk
    import frt_pkg::*;
(
    input wire logic       i_core_clk,
    input wire logic       i_reset_n,
    input wire logic       i_clk_en,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic       i_cpu_irq_mask,
    input wire logic       i_halt_mode,
    input wire logic [7:0] o_rdata,
    input wire logic       o_timer_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    wire logic rd_ok = i_rd && i_clk_en;
    wire logic wr_ok = i_wr && i_clk_en;
    AST_IRQ_MASK: assert property (o_timer_irq |-> !i_cpu_irq_mask)
        else $error("irq high while masked");
    AST_UNMAPPED: assert property (rd_ok && i_addr > FRT_OFS_ALT_LO |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RELOAD: assert property (wr_ok && i_addr == FRT_OFS_CNT_LO ##2
        rd_ok && i_addr == FRT_OFS_CNT_HI |=> o_rdata == 8'hFF) else $error("no reload");
    AST_ALT_RELOAD: assert property (wr_ok && i_addr == FRT_OFS_ALT_LO ##2
        rd_ok && i_addr == FRT_OFS_ALT_HI |=> o_rdata == 8'hFF) else $error("no alt reload");
    AST_FLAG_HOLD: assert property (o_timer_irq && !i_cpu_irq_mask && !i_wr
        && !(rd_ok && i_addr == FRT_OFS_CNT_LO) |=> o_timer_irq || i_cpu_irq_mask)
        else $error("flag lost");
    AST_STATUS_FLAG: assert property (o_timer_irq && rd_ok && i_addr == FRT_OFS_STATUS
        |=> o_rdata[FRT_BIT_OVF_FLAG]) else $error("status flag not read back");
    AST_RESET_IRQ: assert property ($rose(i_reset_n) |-> !o_timer_irq)
        else $error("irq after reset");
    AST_HALT_IRQ: assert property (i_halt_mode && $past(i_halt_mode) && !$past(i_wr)
        && !$fell(i_cpu_irq_mask) |-> !$rose(o_timer_irq)) else $error("overflow in halt");
    cover property ($rose(o_timer_irq));
    cover property (i_halt_mode && rd_ok);
    cover property (wr_ok && i_addr == FRT_OFS_CTRL_TWO && i_wdata[3:2] == FRT_SEL_EXT);
endmodule : frt_core_chk
bind frt_core frt_core_chk i_frt_core_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_cpu_irq_mask(i_cpu_irq_mask), .i_halt_mode(i_halt_mode), .o_rdata(o_rdata),
    .o_timer_irq(o_timer_irq));
`default_nettype wire

// file: tb.sv
// Self-checking bench for the timer counter core.
// Assumes the external source model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, mask = 0, halt = 0, run = 0, bond = 1;
    logic ce = 1, ed = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00, d, l1, l2, rdat;
    logic [15:0] v, s = 16'd14724;
    logic pin, pd = 0, irq;
    int err_count = 0, n_tests = 0, n, ne = 0, dv[3] = '{4, 8, 2};
    initial forever #20 clk = ~clk;
    frt_core i_frt_core (.i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce), .i_addr(addr),
        .i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_ext_clock_pin(pin), .i_ext_pin_bonded(bond),
        .i_cpu_irq_mask(mask), .i_halt_mode(halt), .o_rdata(rdat), .o_timer_irq(irq));
    frt_ext_src i_frt_ext_src (.i_core_clk(clk), .i_run(run), .o_pin(pin));
    // Count active pin edges the way the counter should see them
    always @(posedge clk) begin
        pd <= pin;
        // The pin only moves while the source runs; the last edge lands as run drops
        if (bond && (ed ? pin & ~pd : ~pin & pd)) ne++;
    end
    function automatic logic [15:0] xs();
        s = s ^ (s << 7); s = s ^ (s >> 9); s = s ^ (s << 8);
        return s;
    endfunction : xs
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrr(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk); wr <= 1; addr <= a; wd <= x;
        @(posedge clk); wr <= 0;
    endtask : wrr
    task automatic rdr(input logic [3:0] a, output logic [7:0] x);
        @(posedge clk); rd <= 1; addr <= a;
        @(posedge clk); rd <= 0; #1 x = rdat;
    endtask : rdr
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk); rst_n <= 1;
        rdr(4'h3, v[15:8]); rdr(4'h4, v[7:0]); chk(v, 16'hFFFC);
        wrr(4'h0, 8'h20);
        for (int k = 0; k < 3; k++) begin
            wrr(4'h1, 8'(k << 2)); wrr(4'h4, 8'h00); rdr(4'h3, d); chk(d, 8'hFF);
            n = 0;
            while (irq !== 1'b1 && n < 200) begin @(posedge clk); #1 n++; end
            if (n == 200) begin
                err_count++;
                give_verdict();
            end
            chk(n >= 4 * dv[k] - 3 && n <= 4 * dv[k] + 2, 1);
            @(posedge clk) mask <= 1; #1 chk(irq, 0);
            @(posedge clk) mask <= 0; #1 chk(irq, 1);
            rdr(4'h6, d); chk(irq, 1); rdr(4'h2, d); chk(d[5], 1);
            rdr(4'h4, d); chk(irq, 0);
        end
        wrr(4'h1, 8'h04);
        repeat (3) begin
            rdr(4'h4, l1); rdr(4'h3, d); repeat (xs() % 4) rdr(4'h5, d);
            repeat (40) @(posedge clk); rdr(4'h6, l2); chk(8'(l2 - l1) <= 8'h01, 1);
            rdr(4'h4, d); chk(d != l2, 1);
        end
        @(posedge clk) halt <= 1; rdr(4'h4, l1); repeat (30) @(posedge clk);
        rdr(4'h4, l2); chk(l2, l1); halt <= 0; repeat (30) @(posedge clk);
        rdr(4'h4, l2); chk(l2 != l1, 1);
        rdr(4'h4, l1); @(posedge clk) ce <= 0; repeat (30) @(posedge clk); ce <= 1;
        rdr(4'h4, l2); chk(8'(l2 - l1) <= 8'h01, 1);
        repeat (4) begin rdr(4'(7 + xs() % 9), d); chk(d, 8'h00); end
        for (int j = 0; j < 3; j++) begin
            bond <= (j < 2); ed <= (j % 2 == 1);
            wrr(4'h1, 8'h0C | 8'(j % 2)); repeat (10) @(posedge clk);
            ne = 0; wrr(4'h6, 8'h00); rdr(4'h5, d); chk(d, 8'hFF); rdr(4'h6, d);
            run <= 1; repeat (200) @(posedge clk); run <= 0; repeat (10) @(posedge clk);
            rdr(4'h5, v[15:8]); rdr(4'h6, v[7:0]); chk(v, 16'hFFFC + 16'(ne));
        end
        give_verdict();
    end
endmodule : tb
`default_nettype wire
